/* logic/drive_cfg_pkg.sv */
// constants shared by the drive configuration register bank
package drive_cfg_pkg;
	// ----------------------------------------------------------------
	// object addresses (index and subindex)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_BOOT = 16'h2800;
	localparam logic [15:0] IDX_SUBMODE = 16'h3202;
	localparam logic [15:0] IDX_FB_SEL = 16'h3203;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_REBOOT_TRIGGER = 8'h01;
	localparam logic [7:0] SUB_REBOOT_DELAY = 8'h02;
	localparam logic [7:0] SUB_BOOT_HW = 8'h03;
	localparam logic [7:0] SUB_FB_FIRST = 8'h01;
	localparam logic [7:0] SUB_FB_LAST = 8'h04;
	// ----------------------------------------------------------------
	// reset values and fixed read values
	// ----------------------------------------------------------------
	localparam logic [7:0] REBOOT_ENTRY_COUNT = 8'h03;
	localparam logic [7:0] FB_SEL_COUNT = 8'h04;
	localparam int FB_NUM = 4;
	localparam logic [31:0] REBOOT_MAGIC = 32'h746f6f62;
	localparam logic [31:0] SUBMODE_RESET = 32'h00000000;
	localparam logic [31:0] REBOOT_TRIGGER_RESET = 32'h00000000;
	localparam logic [31:0] REBOOT_DELAY_RESET = 32'h00000000;
	localparam logic [31:0] BOOT_HW_RESET = 32'h00000000;
	localparam logic [7:0] FB_SEL_RESET = 8'h00;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BOOT_NO_SHORT_BIT = 0;
	localparam int SM_LOOP_SELECT = 0;
	localparam int SM_VELOCITY_RAMP = 1;
	localparam int SM_BRAKE = 2;
	localparam int SM_CURRENT_CUT = 3;
	localparam int SM_ROTOR_ALIGN = 4;
	localparam int SM_TORQUE = 5;
	localparam int SM_BRUSHLESS = 6;
	localparam int SM_SLOW = 7;
	localparam int FB_ROLE_POS = 0;
	localparam int FB_ROLE_VEL = 1;
	localparam int FB_ROLE_COMM = 2;
	// sensor number of the always present sensorless feedback
	localparam logic [2:0] FB_SENSORLESS = 3'h1;
	localparam logic [2:0] FB_NONE = 3'h0;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
	// ----------------------------------------------------------------
	// commutation start-up states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OPEN = 2'b00,
		ST_ALIGN = 2'b01,
		ST_WAIT_INDEX = 2'b10,
		ST_CLOSED = 2'b11
	} comm_state_t;
endpackage

/* logic/drive_config_reboot_regs.sv */
// reboot, submode and feedback selection register bank of the drive
`timescale 1ns/1ps

module drive_config_reboot_regs #(
	parameter int MS_TICK = drive_cfg_pkg::MS_TICK_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [15:0] i_index,
	input wire logic [7:0] i_subindex,
	input wire logic [31:0] i_wdata,
	input wire logic i_op_enabled,
	input wire logic i_torque_mode,
	input wire logic i_comm_has_index,
	input wire logic i_align_done,
	input wire logic i_enc_index,
	output logic [31:0] o_rdata,
	output logic o_rd_valid,
	output logic o_access_err,
	output logic o_reboot_req,
	output logic o_reboot_pending,
	output logic o_boot_winding_short,
	output logic o_loop_select,
	output logic o_comm_closed,
	output logic o_rotor_align_auto,
	output logic o_velocity_ramp_emulation,
	output logic o_auto_brake,
	output logic o_open_loop_current_cut,
	output logic o_torque_only,
	output logic o_brushless_motor_type,
	output logic o_slow_speed,
	output logic [2:0] o_pos_src,
	output logic [2:0] o_vel_src,
	output logic [2:0] o_comm_src
);
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic hit_boot;
	logic hit_submode;
	logic hit_fb;
	logic fb_sub_ok;
	logic mapped;
	logic writable;
	logic [1:0] fb_sel_idx;

	assign hit_boot = (i_index == drive_cfg_pkg::IDX_BOOT) &&
		(i_subindex <= drive_cfg_pkg::SUB_BOOT_HW);
	assign hit_submode = (i_index == drive_cfg_pkg::IDX_SUBMODE) &&
		(i_subindex == drive_cfg_pkg::SUB_COUNT);
	assign fb_sub_ok = (i_subindex <= drive_cfg_pkg::SUB_FB_LAST);
	assign hit_fb = (i_index == drive_cfg_pkg::IDX_FB_SEL) && fb_sub_ok;
	assign mapped = hit_boot || hit_submode || hit_fb;
	// count entries are read only
	assign writable = hit_submode ||
		((hit_boot || hit_fb) && (i_subindex != drive_cfg_pkg::SUB_COUNT));
	assign fb_sel_idx = 2'(i_subindex - drive_cfg_pkg::SUB_FB_FIRST);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0] submode;
	logic [31:0] reboot_trigger;
	logic [31:0] reboot_delay_ms;
	logic [31:0] boot_hw_setting;
	logic [7:0] fb_sel [drive_cfg_pkg::FB_NUM];
	logic [7:0] fb_act [drive_cfg_pkg::FB_NUM];
	logic wr_ok;
	logic magic_wr;

	assign wr_ok = i_wr_en && writable;
	assign magic_wr = wr_ok && hit_boot &&
		(i_subindex == drive_cfg_pkg::SUB_REBOOT_TRIGGER) &&
		(i_wdata == drive_cfg_pkg::REBOOT_MAGIC);

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			submode <= drive_cfg_pkg::SUBMODE_RESET;
		end else if (wr_ok && hit_submode) begin
			submode <= i_wdata;
			// the loop choice cannot move under a running drive
			if (i_op_enabled) begin
				submode[drive_cfg_pkg::SM_LOOP_SELECT] <=
					submode[drive_cfg_pkg::SM_LOOP_SELECT];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			reboot_trigger <= drive_cfg_pkg::REBOOT_TRIGGER_RESET;
			reboot_delay_ms <= drive_cfg_pkg::REBOOT_DELAY_RESET;
			boot_hw_setting <= drive_cfg_pkg::BOOT_HW_RESET;
		end else if (wr_ok && hit_boot) begin
			case (i_subindex)
				drive_cfg_pkg::SUB_REBOOT_TRIGGER: begin
					reboot_trigger <= i_wdata;
				end
				drive_cfg_pkg::SUB_REBOOT_DELAY: begin
					reboot_delay_ms <= i_wdata;
				end
				drive_cfg_pkg::SUB_BOOT_HW: begin
					boot_hw_setting <= i_wdata;
				end
				default: begin
					reboot_trigger <= reboot_trigger;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int k = 0; k < drive_cfg_pkg::FB_NUM; k++) begin
				fb_sel[k] <= drive_cfg_pkg::FB_SEL_RESET;
			end
		end else if (wr_ok && hit_fb) begin
			fb_sel[fb_sel_idx] <= i_wdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// active selection copy
	// ----------------------------------------------------------------
	logic op_enabled_q;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			op_enabled_q <= 1'b0;
		end else begin
			op_enabled_q <= i_op_enabled;
		end
	end

	// outside operation the copy tracks the buffer; it freezes on entry
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int k = 0; k < drive_cfg_pkg::FB_NUM; k++) begin
				fb_act[k] <= drive_cfg_pkg::FB_SEL_RESET;
			end
		end else if (!op_enabled_q) begin
			fb_act <= fb_sel;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h00000000;
		if (hit_submode) begin
			next_rdata = submode;
		end else if (hit_boot) begin
			case (i_subindex)
				drive_cfg_pkg::SUB_COUNT: begin
					next_rdata = {24'h000000,
						drive_cfg_pkg::REBOOT_ENTRY_COUNT};
				end
				drive_cfg_pkg::SUB_REBOOT_TRIGGER: begin
					next_rdata = reboot_trigger;
				end
				drive_cfg_pkg::SUB_REBOOT_DELAY: begin
					next_rdata = reboot_delay_ms;
				end
				default: begin
					next_rdata = boot_hw_setting;
				end
			endcase
		end else if (hit_fb) begin
			if (i_subindex == drive_cfg_pkg::SUB_COUNT) begin
				next_rdata = {24'h000000,
					drive_cfg_pkg::FB_SEL_COUNT};
			end else begin
				next_rdata = {24'h000000, fb_sel[fb_sel_idx]};
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 32'h00000000;
			o_rd_valid <= 1'b0;
			o_access_err <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_en;
			o_access_err <= (i_rd_en && !mapped) ||
				(i_wr_en && !writable);
			if (i_rd_en) begin
				o_rdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// delayed reboot
	// ----------------------------------------------------------------
	logic [31:0] ms_prescale;
	logic [31:0] ms_left;
	logic ms_tick;

	assign ms_tick = (ms_prescale == 32'(MS_TICK - 1));

	// the prescaler restarts at the magic write so a full ms is counted
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ms_prescale <= 32'h00000000;
		end else if (magic_wr || ms_tick || !o_reboot_pending) begin
			ms_prescale <= 32'h00000000;
		end else begin
			ms_prescale <= ms_prescale + 32'h00000001;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reboot_pending <= 1'b0;
			ms_left <= 32'h00000000;
			o_reboot_req <= 1'b0;
		end else begin
			o_reboot_req <= 1'b0;
			if (magic_wr) begin
				ms_left <= reboot_delay_ms;
				o_reboot_pending <= 1'b1;
			end else if (o_reboot_pending && ms_left == 32'h00000000) begin
				o_reboot_pending <= 1'b0;
				o_reboot_req <= 1'b1;
			end else if (o_reboot_pending && ms_tick) begin
				ms_left <= ms_left - 32'h00000001;
			end
		end
	end

	assign o_boot_winding_short =
		!boot_hw_setting[drive_cfg_pkg::BOOT_NO_SHORT_BIT];

	// ----------------------------------------------------------------
	// commutation start-up
	// ----------------------------------------------------------------
	logic index_meta;
	logic index_sync;
	logic need_align;
	drive_cfg_pkg::comm_state_t comm_state;

	// index pulse comes from the encoder pin
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			index_meta <= 1'b0;
			index_sync <= 1'b0;
		end else begin
			index_meta <= i_enc_index;
			index_sync <= index_meta;
		end
	end

	assign need_align = submode[drive_cfg_pkg::SM_ROTOR_ALIGN] ||
		!i_comm_has_index;

	// start-up runs once per loop selection: alignment when needed, else index wait; a loop switch restarts it
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			comm_state <= drive_cfg_pkg::ST_OPEN;
		end else if (!o_loop_select) begin
			comm_state <= drive_cfg_pkg::ST_OPEN;
		end else begin
			case (comm_state)
				drive_cfg_pkg::ST_OPEN: begin
					comm_state <= need_align ? drive_cfg_pkg::ST_ALIGN :
						drive_cfg_pkg::ST_WAIT_INDEX;
				end
				drive_cfg_pkg::ST_ALIGN: begin
					if (i_align_done) begin
						comm_state <= drive_cfg_pkg::ST_CLOSED;
					end
				end
				drive_cfg_pkg::ST_WAIT_INDEX: begin
					if (index_sync) begin
						comm_state <= drive_cfg_pkg::ST_CLOSED;
					end
				end
				drive_cfg_pkg::ST_CLOSED: begin
					comm_state <= drive_cfg_pkg::ST_CLOSED;
				end
				default: begin
					comm_state <= drive_cfg_pkg::ST_OPEN;
				end
			endcase
		end
	end

	assign o_loop_select = submode[drive_cfg_pkg::SM_LOOP_SELECT];
	assign o_comm_closed = (comm_state == drive_cfg_pkg::ST_CLOSED);
	assign o_rotor_align_auto = (comm_state == drive_cfg_pkg::ST_ALIGN);

	// ----------------------------------------------------------------
	// submode controls
	// ----------------------------------------------------------------
	assign o_velocity_ramp_emulation =
		submode[drive_cfg_pkg::SM_VELOCITY_RAMP];
	assign o_auto_brake = submode[drive_cfg_pkg::SM_BRAKE];
	assign o_open_loop_current_cut =
		submode[drive_cfg_pkg::SM_CURRENT_CUT] && !o_comm_closed;
	assign o_torque_only =
		submode[drive_cfg_pkg::SM_TORQUE] && i_torque_mode;
	assign o_brushless_motor_type =
		submode[drive_cfg_pkg::SM_BRUSHLESS];
	assign o_slow_speed =
		submode[drive_cfg_pkg::SM_SLOW] && o_comm_closed;

	// ----------------------------------------------------------------
	// feedback source search
	// ----------------------------------------------------------------
	// sensor 1 is the fallback when no other sensor claims a role
	function automatic logic [2:0] find_src(input int role);
		logic [2:0] src;
		src = drive_cfg_pkg::FB_SENSORLESS;
		for (int k = drive_cfg_pkg::FB_NUM - 1; k >= 1; k--) begin
			if (fb_act[k][role]) begin
				src = 3'(k + 1);
			end
		end
		return src;
	endfunction

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pos_src <= drive_cfg_pkg::FB_SENSORLESS;
			o_vel_src <= drive_cfg_pkg::FB_SENSORLESS;
			o_comm_src <= drive_cfg_pkg::FB_NONE;
		end else begin
			o_pos_src <= find_src(drive_cfg_pkg::FB_ROLE_POS);
			o_vel_src <= find_src(drive_cfg_pkg::FB_ROLE_VEL);
			o_comm_src <= o_loop_select ?
				find_src(drive_cfg_pkg::FB_ROLE_COMM) :
				drive_cfg_pkg::FB_NONE;
		end
	end
endmodule // drive_config_reboot_regs

/* testbench/drive_config_reboot_regs_checker.sv */
// assertions on the ports of the drive configuration register bank
`timescale 1ns/1ps
module drive_config_reboot_regs_checker (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [15:0] i_index,
	input wire logic [7:0] i_subindex,
	input wire logic [31:0] i_wdata,
	input wire logic i_op_enabled,
	input wire logic o_rd_valid,
	input wire logic o_access_err,
	input wire logic o_reboot_req,
	input wire logic o_reboot_pending,
	input wire logic o_boot_winding_short,
	input wire logic o_loop_select,
	input wire logic o_comm_closed,
	input wire logic o_slow_speed,
	input wire logic [2:0] o_pos_src,
	input wire logic [2:0] o_comm_src
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	sequence s_boot_wr(logic [7:0] sub);
		i_wr_en && i_index == drive_cfg_pkg::IDX_BOOT && i_subindex == sub;
	endsequence
	sequence s_magic;
		s_boot_wr(drive_cfg_pkg::SUB_REBOOT_TRIGGER)
			##0 i_wdata == drive_cfg_pkg::REBOOT_MAGIC;
	endsequence
	property p_magic;
		s_magic |=> o_reboot_pending;
	endproperty
	a_magic: assert property (p_magic) else $error("no countdown");
	property p_req;
		o_reboot_req |-> $past(o_reboot_pending) && !o_reboot_pending;
	endproperty
	a_req: assert property (p_req) else $error("stray restart");
	property p_short;
		s_boot_wr(drive_cfg_pkg::SUB_BOOT_HW)
			|=> o_boot_winding_short == !$past(i_wdata[0]);
	endproperty
	a_short: assert property (p_short) else $error("short level");
	property p_lock;
		i_wr_en && i_index == drive_cfg_pkg::IDX_SUBMODE && i_op_enabled
			|=> $stable(o_loop_select);
	endproperty
	a_lock: assert property (p_lock) else $error("loop changed");
	property p_slow;
		o_slow_speed |-> o_comm_closed;
	endproperty
	a_slow: assert property (p_slow) else $error("slow open");
	property p_closed;
		$rose(o_comm_closed) |-> o_loop_select;
	endproperty
	a_closed: assert property (p_closed) else $error("closed bad");
	property p_open_comm;
		!o_loop_select [*4] |-> o_comm_src == drive_cfg_pkg::FB_NONE;
	endproperty
	a_open_comm: assert property (p_open_comm) else $error("comm");
	property p_sensorless;
		o_pos_src != drive_cfg_pkg::FB_NONE;
	endproperty
	a_sensorless: assert property (p_sensorless)
		else $error("pos");
	property p_read;
		i_rd_en |=> o_rd_valid;
	endproperty
	a_read: assert property (p_read) else $error("no answer");
	property p_ro;
		s_boot_wr(drive_cfg_pkg::SUB_COUNT) |=> o_access_err;
	endproperty
	a_ro: assert property (p_ro) else $error("count written");
endmodule // drive_config_reboot_regs_checker

bind drive_config_reboot_regs drive_config_reboot_regs_checker u_chk (
	.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_wr_en(i_wr_en),
	.i_rd_en(i_rd_en), .i_index(i_index), .i_subindex(i_subindex),
	.i_wdata(i_wdata), .i_op_enabled(i_op_enabled), .o_rd_valid(o_rd_valid),
	.o_access_err(o_access_err), .o_reboot_req(o_reboot_req),
	.o_reboot_pending(o_reboot_pending), .o_loop_select(o_loop_select),
	.o_boot_winding_short(o_boot_winding_short),
	.o_comm_closed(o_comm_closed), .o_slow_speed(o_slow_speed),
	.o_pos_src(o_pos_src), .o_comm_src(o_comm_src)
);

/* testbench/fieldbus_master_model.sv */
// fieldbus master model issuing object reads and writes
`timescale 1ns/1ps
module fieldbus_master_model (
	input wire logic i_clk_sys,
	input wire logic [31:0] i_rdata,
	input wire logic i_access_err,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [15:0] o_index,
	output logic [7:0] o_subindex,
	output logic [31:0] o_wdata
);
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_index = 16'h0000;
		o_subindex = 8'h00;
		o_wdata = 32'h00000000;
	end
	// one access: strobe for one edge, answer read in the next cycle
	task automatic xfer(input logic w, input logic [15:0] idx,
		input logic [7:0] sub, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge i_clk_sys);
		o_wr_en <= w;
		o_rd_en <= !w;
		o_index <= idx;
		o_subindex <= sub;
		o_wdata <= d;
		@(posedge i_clk_sys);
		o_wr_en <= 1'b0;
		o_rd_en <= 1'b0;
		// released index and data lines carry an inverted pattern; the subindex keeps its value
		o_index <= ~idx;
		o_wdata <= ~d;
		@(negedge i_clk_sys);
		q = i_rdata;
		err = i_access_err;
	endtask
endmodule // fieldbus_master_model

/* testbench/drive_config_reboot_regs_bench.sv */
// self-checking bench for the drive configuration register bank
`timescale 1ns/1ps
module drive_config_reboot_regs_bench;
	localparam int TICK = 10;
	localparam logic [15:0] idx_b = 16'h2800;
	localparam logic [15:0] idx_s = 16'h3202;
	localparam logic [15:0] idx_f = 16'h3203;
	logic clk_sys, arst_n, op_en, torque, has_idx, align_done, enc_idx;
	logic wr_en, rd_en, err, req, pend, short, loop_sel, closed, align;
	logic ramp, brake, cut, torque_only, brushless_motor_type, slow, rd_valid;
	logic [15:0] index;
	logic [7:0] subindex;
	logic [31:0] wdata, rdata;
	logic [2:0] pos_src, vel_src, comm_src;
	int n_fail, cmp_count, cyc_cnt;
	drive_config_reboot_regs #(.MS_TICK(TICK)) u_dut (
		.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_wr_en(wr_en),
		.i_rd_en(rd_en), .i_index(index), .i_subindex(subindex),
		.i_wdata(wdata), .i_op_enabled(op_en), .i_torque_mode(torque),
		.i_comm_has_index(has_idx), .i_align_done(align_done),
		.i_enc_index(enc_idx), .o_rdata(rdata), .o_rd_valid(rd_valid),
		.o_access_err(err), .o_reboot_req(req), .o_reboot_pending(pend),
		.o_boot_winding_short(short), .o_loop_select(loop_sel),
		.o_comm_closed(closed), .o_rotor_align_auto(align),
		.o_velocity_ramp_emulation(ramp), .o_auto_brake(brake),
		.o_open_loop_current_cut(cut), .o_torque_only(torque_only),
		.o_brushless_motor_type(brushless_motor_type), .o_slow_speed(slow),
		.o_pos_src(pos_src), .o_vel_src(vel_src), .o_comm_src(comm_src)
	);
	fieldbus_master_model u_mst (
		.i_clk_sys(clk_sys), .i_rdata(rdata), .i_access_err(err),
		.o_wr_en(wr_en), .o_rd_en(rd_en), .o_index(index),
		.o_subindex(subindex), .o_wdata(wdata)
	);
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d);
		logic [31:0] q;
		logic e;
		u_mst.xfer(1'b1, i, s, d, q, e);
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		u_mst.xfer(1'b0, i, s, 32'h0, q, e);
		chk("valid", rd_valid, 1'b1);
		chk("rdata", q, x);
		chk("err", e, xe);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] q;
		logic e;
		rd(idx_b, 8'h00, 32'h03, 1'b0);
		rd(idx_f, 8'h00, 32'h04, 1'b0);
		rd(idx_f, 8'h04, 32'h00, 1'b0);
		rd(16'h1234, 8'h00, 32'h00, 1'b1);
		u_mst.xfer(1'b1, idx_b, 8'h00, 32'h55, q, e);
		chk("ro_err", e, 1'b1);
		rd(idx_b, 8'h00, 32'h03, 1'b0);
		chk("short", short, 1'b1);
		chk("pos", pos_src, 3'h1);
		wr(idx_b, 8'h03, 32'h1);
		chk("short_off", short, 1'b0);
		wr(idx_b, 8'h03, 32'h0);
		chk("short_on", short, 1'b1);
	endtask
	task automatic t_reboot(input int d);
		int n;
		wr(idx_b, 8'h02, d);
		wr(idx_b, 8'h01, 32'h746f6f62);
		n = 0;
		while (req !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		chk("wait", n >= d * TICK && n <= d * TICK + 3, 1'b1);
		wr(idx_b, 8'h01, 32'h746f6f63);
		cyc(3);
		chk("no_boot", pend | req, 1'b0);
		rd(idx_b, 8'h01, 32'h746f6f63, 1'b0);
	endtask
	task automatic t_submode;
		logic [7:0] e;
		@(posedge clk_sys) torque <= 1'b1;
		for (int b = 1; b < 7; b++) begin
			wr(idx_s, 8'h00, 32'h1 << b);
			e = 8'h1 << b;
			chk("ramp", ramp, e[1]);
			chk("brake", brake, e[2]);
			chk("cut", cut, e[3]);
			chk("torque", torque_only, e[5]);
			chk("brushless_motor_type", brushless_motor_type, e[6]);
			chk("loop", loop_sel, 1'b0);
		end
		@(posedge clk_sys) torque <= 1'b0;
		wr(idx_s, 8'h00, 32'h20);
		chk("no_torque", torque_only, 1'b0);
	endtask
	task automatic t_comm;
		wr(idx_s, 8'h00, 32'h1);
		cyc(6);
		chk("idx_wait", closed, 1'b0);
		@(posedge clk_sys) enc_idx <= 1'b1;
		@(posedge clk_sys) enc_idx <= 1'b0;
		cyc(4);
		chk("closed", closed, 1'b1);
		wr(idx_s, 8'h00, 32'h89); // slow only once closed
		chk("slow", slow, 1'b1);
		chk("cut_cl", cut, 1'b0);
		for (int k = 0; k < 2; k++) begin
			wr(idx_s, 8'h00, 32'h0);
			@(posedge clk_sys) has_idx <= k[0];
			wr(idx_s, 8'h00, k ? 32'h11 : 32'h1);
			cyc(2);
			chk("align", align, 1'b1);
			@(posedge clk_sys) align_done <= 1'b1;
			@(posedge clk_sys) align_done <= 1'b0;
			cyc(2);
			chk("aligned", closed, 1'b1);
		end
	endtask
	task automatic t_fb;
		@(posedge clk_sys) op_en <= 1'b1;
		cyc(2);
		wr(idx_s, 8'h00, 32'h0);
		chk("loop_lock", loop_sel, 1'b1);
		wr(idx_f, 8'h02, 32'h1);
		cyc(4);
		chk("frozen", pos_src, 3'h1);
		@(posedge clk_sys) op_en <= 1'b0;
		cyc(2);
		@(posedge clk_sys) op_en <= 1'b1;
		cyc(4);
		chk("applied", pos_src, 3'h2);
		@(posedge clk_sys) op_en <= 1'b0;
		wr(idx_f, 8'h02, 32'h2);
		wr(idx_f, 8'h03, 32'h1);
		wr(idx_f, 8'h04, 32'h7);
		cyc(4);
		chk("pos", pos_src, 3'h3);
		chk("vel", vel_src, 3'h2);
		chk("comm", comm_src, 3'h4);
		rd(idx_f, 8'h04, 32'h7, 1'b0);
		wr(idx_f, 8'h04, 32'h0);
		cyc(4);
		chk("comm_dflt", comm_src, 3'h1);
		wr(idx_s, 8'h00, 32'h0);
		cyc(4);
		chk("comm_open", comm_src, 3'h0);
		chk("pos_open", pos_src, 3'h3);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_fail++;
			stop_test;
		end
	end
	initial begin
		arst_n = 1'b0;
		op_en = 1'b0;
		torque = 1'b0;
		has_idx = 1'b1;
		align_done = 1'b0;
		enc_idx = 1'b0;
		n_fail = 0;
		cmp_count = 0;
		cyc_cnt = 0;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset;
		t_reboot(0);
		t_reboot(3);
		t_submode;
		t_comm;
		t_fb;
		stop_test;
	end
endmodule // drive_config_reboot_regs_bench
